// [hw/upsf_master.sv]
// Purpose: Master end, sends cyclic and service datagrams, times answers
// Assumes: Station end answers each cyclic request with 64 bytes
// Notes: Timeout tracks five times the last measured scan
`timescale 1ns/1ps
`include "upsf_cfg.svh"
module upsf_master
	import upsf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Link
	upsf_link_if.master link,
	// Network setup
	input wire logic [31:0] own_ip_in,
	input wire logic [31:0] own_mask_in,
	input wire logic [31:0] target_ip_in,
	// Request
	input wire logic start_in,
	input wire logic [15:0] port_in,
	input wire upsf_cmd_t cmd_in,
	input wire logic [5:0] station_in,
	input wire logic [31:0] new_ip_in,
	input wire logic tx_wr_in,
	input wire logic [4:0] tx_addr_in,
	input wire upsf_word_t tx_data_in,
	// Answer
	output logic busy_out,
	output logic refused_out,
	output logic rx_valid_out,
	output upsf_word_t rx_word_out,
	output logic done_out,
	output logic timeout_out
);
	typedef enum logic [1:0] {
		UPSF_M_IDLE = 2'b00,
		UPSF_M_HDR = 2'b01,
		UPSF_M_SEND = 2'b10,
		UPSF_M_WAIT = 2'b11
	} upsf_mstate_t;

	upsf_word_t tx_mem [0:31];
	upsf_mstate_t state, next_state;
	logic [6:0] idx, next_idx;
	logic [15:0] port, next_port;
	upsf_cmd_t cmd, next_cmd;
	logic [5:0] station, next_station;
	logic [31:0] new_ip, next_new_ip;
	logic [18:0] scan, next_scan, limit, next_limit;
	logic [7:0] lo_byte, next_lo_byte;
	logic rx_half, next_rx_half;
	logic refused, next_refused, rx_valid, next_rx_valid, done, next_done;
	logic tout, next_tout;
	upsf_word_t rx_word, next_rx_word;
	logic same_net;

	// Payload store written by the user side
	always_ff @(posedge sys_clk_in) begin
		if (tx_wr_in) begin
			tx_mem[tx_addr_in] <= tx_data_in;
		end
	end

	// Requests only go to stations sharing our network portion
	assign same_net = ((own_ip_in ^ target_ip_in) & own_mask_in) == 32'h00000000;

	// Next state: header beat, cyclic bytes, then wait for the answer
	always_comb begin
		next_state = state;
		next_idx = idx;
		next_port = port;
		next_cmd = cmd;
		next_station = station;
		next_new_ip = new_ip;
		next_scan = scan;
		next_limit = limit;
		next_lo_byte = lo_byte;
		next_rx_half = rx_half;
		next_refused = 1'b0;
		next_rx_valid = 1'b0;
		next_done = 1'b0;
		next_tout = 1'b0;
		next_rx_word = rx_word;
		case (state)
			UPSF_M_IDLE: begin
				if (start_in) begin
					if (!same_net) begin
						next_refused = 1'b1;
					end else begin
						next_port = (cmd_in == UPSF_CMD_CYCLIC) ? `UPSF_PORT_CYCLIC : port_in;
						next_cmd = cmd_in;
						next_station = station_in;
						next_new_ip = new_ip_in;
						next_state = UPSF_M_HDR;
					end
				end
			end
			UPSF_M_HDR: begin
				next_idx = 7'h00;
				next_scan = 19'h00000;
				next_rx_half = 1'b0;
				next_state = (cmd == UPSF_CMD_CYCLIC) ? UPSF_M_SEND : UPSF_M_IDLE;
			end
			UPSF_M_SEND: begin
				next_idx = idx + 7'h01;
				next_scan = scan + 19'h00001;
				if (idx == `UPSF_CYC_BYTES - 7'h01) begin
					next_state = UPSF_M_WAIT;
				end
			end
			default: begin
				next_scan = scan + 19'h00001;
				if (link.rsp_valid) begin
					next_rx_half = !rx_half;
					if (!rx_half) begin
						next_lo_byte = link.rsp_data;
					end else begin
						next_rx_word = {link.rsp_data, lo_byte};
						next_rx_valid = 1'b1;
					end
					if (link.rsp_last) begin
						// Five scans of headroom before a station counts as lost
						next_limit = 19'(scan * `UPSF_TIMEOUT_MULT);
						next_done = 1'b1;
						next_state = UPSF_M_IDLE;
					end
				end else if (limit != 19'h00000 && scan >= limit) begin
					next_tout = 1'b1;
					next_state = UPSF_M_IDLE;
				end
			end
		endcase
	end

	// Register the master state
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= UPSF_M_IDLE;
			idx <= 7'h00;
			port <= 16'h0000;
			cmd <= UPSF_CMD_CYCLIC;
			station <= 6'h00;
			new_ip <= 32'h00000000;
			scan <= 19'h00000;
			limit <= 19'h00000;
			lo_byte <= 8'h00;
			rx_half <= 1'b0;
			refused <= 1'b0;
			rx_valid <= 1'b0;
			done <= 1'b0;
			tout <= 1'b0;
			rx_word <= 16'h0000;
		end else begin
			state <= next_state;
			idx <= next_idx;
			port <= next_port;
			cmd <= next_cmd;
			station <= next_station;
			new_ip <= next_new_ip;
			scan <= next_scan;
			limit <= next_limit;
			lo_byte <= next_lo_byte;
			rx_half <= next_rx_half;
			refused <= next_refused;
			rx_valid <= next_rx_valid;
			done <= next_done;
			tout <= next_tout;
			rx_word <= next_rx_word;
		end
	end

	// Link drive, low byte of each word first
	assign link.hdr_valid = (state == UPSF_M_HDR);
	assign link.src_ip = own_ip_in;
	assign link.dst_port = port;
	assign link.cmd = cmd;
	assign link.station = station;
	assign link.new_ip = new_ip;
	assign link.byte_valid = (state == UPSF_M_SEND);
	assign link.byte_data = idx[0] ? tx_mem[idx[5:1]][15:8] : tx_mem[idx[5:1]][7:0];
	assign link.byte_last = (state == UPSF_M_SEND) && (idx == `UPSF_CYC_BYTES - 7'h01);
	assign busy_out = (state != UPSF_M_IDLE);
	assign refused_out = refused;
	assign rx_valid_out = rx_valid;
	assign rx_word_out = rx_word;
	assign done_out = done;
	assign timeout_out = tout;
endmodule // upsf_master

// [hw/upsf_station.sv]
// Purpose: Station end, sorts datagrams by port and filters sources
// Assumes: Master end sends header beat then payload bytes
// Notes: Summary of operation below
`timescale 1ns/1ps
`include "upsf_cfg.svh"
module upsf_station
	import upsf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Link
	upsf_link_if.station_end link,
	// Configuration
	input wire logic fixed_proto_in,
	input wire logic [31:0] filter_lo_in,
	input wire logic [31:0] filter_hi_in,
	input wire logic [31:0] oper_lo_in,
	input wire logic [31:0] oper_hi_in,
	input wire logic safety_unit_in,
	// Response payload
	input wire logic tx_wr_in,
	input wire logic [4:0] tx_addr_in,
	input wire upsf_word_t tx_data_in,
	// Station state
	output logic [31:0] station_ip_out,
	output logic [31:0] subnet_mask_out,
	output logic safety_unit_conflict_alarm_out,
	// Events
	output logic rx_valid_out,
	output logic [4:0] rx_index_out,
	output upsf_word_t rx_word_out,
	output logic node_discovery_request_out,
	output logic address_assign_request_out,
	output logic assign_reject_out,
	output logic monitor_out,
	output logic param_read_out,
	output logic operate_out,
	output logic refuse_out,
	output logic drop_out
);
	typedef enum logic [1:0] {
		UPSF_S_IDLE = 2'b00,
		UPSF_S_RECV = 2'b01,
		UPSF_S_DROP = 2'b10,
		UPSF_S_RESP = 2'b11
	} upsf_sstate_t;

	upsf_word_t tx_mem [0:31];
	upsf_sstate_t state, next_state;
	logic [6:0] idx, next_idx;
	logic [7:0] lo_byte, next_lo_byte;
	logic [31:0] ip, next_ip;
	logic rx_valid, next_rx_valid;
	logic [4:0] rx_index, next_rx_index;
	upsf_word_t rx_word, next_rx_word;
	logic disc, next_disc, asg, next_asg, rej, next_rej;
	logic mon, next_mon, prd, next_prd, opr, next_opr, refu, next_refu;
	logic drop, next_drop;
	logic safe_meta, safe_sync, alarm;
	logic src_ok, oper_ok, ip_ok, disc_port;

	// Payload for answers, written by the user side
	always_ff @(posedge sys_clk_in) begin
		if (tx_wr_in) begin
			tx_mem[tx_addr_in] <= tx_data_in;
		end
	end

	// Safety unit detect is a pin, so synchronise before use
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			safe_meta <= 1'b0;
			safe_sync <= 1'b0;
		end else begin
			safe_meta <= safety_unit_in;
			safe_sync <= safe_meta;
		end
	end

	// Alarm silences the whole link instead of half-working
	assign alarm = fixed_proto_in && safe_sync;

	// Address checks on each header
	assign src_ok = (link.src_ip >= filter_lo_in) && (link.src_ip <= filter_hi_in);
	assign oper_ok = (link.src_ip >= oper_lo_in) && (link.src_ip <= oper_hi_in);
	// General protocol takes every address, fixed-cycle a bounded span
	assign ip_ok = !fixed_proto_in ||
		((link.new_ip >= `UPSF_FIX_IP_MIN) && (link.new_ip <= `UPSF_FIX_IP_MAX));
	// Each protocol keeps its own discovery port
	assign disc_port = fixed_proto_in ? (link.dst_port == `UPSF_PORT_FIX_DISC) :
		(link.dst_port == `UPSF_PORT_GEN_DISC);

	// Next state: classify header, collect or skip payload, answer cyclic
	always_comb begin
		next_state = state;
		next_idx = idx;
		next_lo_byte = lo_byte;
		next_ip = ip;
		next_rx_valid = 1'b0;
		next_rx_index = rx_index;
		next_rx_word = rx_word;
		next_disc = 1'b0;
		next_asg = 1'b0;
		next_rej = 1'b0;
		next_mon = 1'b0;
		next_prd = 1'b0;
		next_opr = 1'b0;
		next_refu = 1'b0;
		next_drop = 1'b0;
		case (state)
			UPSF_S_IDLE: begin
				if (link.hdr_valid) begin
					next_idx = 7'h00;
					if (alarm || !src_ok) begin
						next_drop = 1'b1;
					end else if (link.dst_port == `UPSF_PORT_CYCLIC &&
						link.cmd == UPSF_CMD_CYCLIC) begin
						next_state = UPSF_S_RECV;
					end else if (disc_port && link.cmd == UPSF_CMD_DISCOVER) begin
						next_disc = 1'b1;
					end else if (disc_port && link.cmd == UPSF_CMD_ASSIGN) begin
						if (ip_ok) begin
							next_asg = 1'b1;
							next_ip = link.new_ip;
						end else begin
							next_rej = 1'b1;
						end
					end else if (!fixed_proto_in && link.dst_port == `UPSF_PORT_GEN_MSG) begin
						// Reads and monitoring stay open to every permitted source
						if (link.cmd == UPSF_CMD_MONITOR) begin
							next_mon = 1'b1;
						end else if (link.cmd == UPSF_CMD_PARAM_READ) begin
							next_prd = 1'b1;
						end else if (link.cmd == UPSF_CMD_OPERATE && oper_ok) begin
							next_opr = 1'b1;
						end else begin
							next_refu = 1'b1;
						end
					end else begin
						next_drop = 1'b1;
					end
				end
			end
			UPSF_S_RECV: begin
				if (link.byte_valid) begin
					next_idx = idx + 7'h01;
					if (!idx[0]) begin
						next_lo_byte = link.byte_data;
					end else begin
						next_rx_word = {link.byte_data, lo_byte};
						next_rx_index = idx[5:1];
						next_rx_valid = 1'b1;
					end
					// Frame shorter or longer than 64 bytes is not a cyclic frame
					if (link.byte_last) begin
						next_idx = 7'h00;
						if (idx == `UPSF_CYC_BYTES - 7'h01) begin
							next_state = UPSF_S_RESP;
						end else begin
							next_drop = 1'b1;
							next_state = UPSF_S_IDLE;
						end
					end else if (idx == `UPSF_CYC_BYTES - 7'h01) begin
						next_drop = 1'b1;
						next_state = UPSF_S_DROP;
					end
				end
			end
			UPSF_S_DROP: begin
				if (link.byte_valid && link.byte_last) begin
					next_state = UPSF_S_IDLE;
				end
			end
			default: begin
				next_idx = idx + 7'h01;
				if (idx == `UPSF_CYC_BYTES - 7'h01) begin
					next_idx = 7'h00;
					next_state = UPSF_S_IDLE;
				end
			end
		endcase
	end

	// Register the station state
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= UPSF_S_IDLE;
			idx <= 7'h00;
			lo_byte <= 8'h00;
			ip <= `UPSF_DEF_IP;
			rx_valid <= 1'b0;
			rx_index <= 5'h00;
			rx_word <= 16'h0000;
			disc <= 1'b0;
			asg <= 1'b0;
			rej <= 1'b0;
			mon <= 1'b0;
			prd <= 1'b0;
			opr <= 1'b0;
			refu <= 1'b0;
			drop <= 1'b0;
		end else begin
			state <= next_state;
			idx <= next_idx;
			lo_byte <= next_lo_byte;
			ip <= next_ip;
			rx_valid <= next_rx_valid;
			rx_index <= next_rx_index;
			rx_word <= next_rx_word;
			disc <= next_disc;
			asg <= next_asg;
			rej <= next_rej;
			mon <= next_mon;
			prd <= next_prd;
			opr <= next_opr;
			refu <= next_refu;
			drop <= next_drop;
		end
	end

	// Answer bytes, low byte of each word first
	assign link.rsp_valid = (state == UPSF_S_RESP);
	assign link.rsp_data = idx[0] ? tx_mem[idx[5:1]][15:8] : tx_mem[idx[5:1]][7:0];
	assign link.rsp_last = (state == UPSF_S_RESP) && (idx == `UPSF_CYC_BYTES - 7'h01);

	// User side outputs
	assign station_ip_out = ip;
	assign subnet_mask_out = `UPSF_DEF_MASK;
	assign safety_unit_conflict_alarm_out = alarm;
	assign rx_valid_out = rx_valid;
	assign rx_index_out = rx_index;
	assign rx_word_out = rx_word;
	assign node_discovery_request_out = disc;
	assign address_assign_request_out = asg;
	assign assign_reject_out = rej;
	assign monitor_out = mon;
	assign param_read_out = prd;
	assign operate_out = opr;
	assign refuse_out = refu;
	assign drop_out = drop;
endmodule // upsf_station

// [pkg/upsf_cfg.svh]
// Purpose: Constants for the UDP port station filter link
// Assumes: One 10 MHz clock shared by both ends
// Notes: Addresses and ports are plain 32/16-bit values
`ifndef UPSF_CFG_SVH
`define UPSF_CFG_SVH
`define UPSF_PORT_CYCLIC 16'hf00a
`define UPSF_PORT_FIX_DISC 16'hf00b
`define UPSF_PORT_GEN_DISC 16'hb0b5
`define UPSF_PORT_GEN_MSG 16'h1392
`define UPSF_CYC_WORDS 6'h20
`define UPSF_CYC_BYTES 7'h40
`define UPSF_FIX_IP_MIN 32'h00000001
`define UPSF_FIX_IP_MAX 32'hdffffffe
`define UPSF_DEF_IP 32'hc0a80300
`define UPSF_DEF_MASK 32'hffffff00
`define UPSF_TIMEOUT_MULT 3'h5
`define UPSF_MAX_STATION 7'h40
`define UPSF_GROUP_SIZE 5'h10
`endif

// [pkg/upsf_link_if.sv]
// Purpose: Datagram link between master end and station end
// Assumes: Both ends on the same clock
// Notes: Header beat first, then payload bytes ending in last
`timescale 1ns/1ps
interface upsf_link_if;
	import upsf_pkg::*;
	logic hdr_valid;
	logic [31:0] src_ip;
	logic [15:0] dst_port;
	upsf_cmd_t cmd;
	logic [5:0] station;
	logic [31:0] new_ip;
	logic byte_valid;
	logic [7:0] byte_data;
	logic byte_last;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_last;
	modport master (output hdr_valid, src_ip, dst_port, cmd, station, new_ip, byte_valid,
		byte_data, byte_last, input rsp_valid, rsp_data, rsp_last);
	modport station_end (input hdr_valid, src_ip, dst_port, cmd, station, new_ip, byte_valid,
		byte_data, byte_last, output rsp_valid, rsp_data, rsp_last);
endinterface

// [pkg/upsf_pkg.sv]
// Purpose: Types shared by both ends of the station filter link
// Assumes: Included constants header defines the figures
// Notes: Command kinds travel with each datagram header
package upsf_pkg;
	typedef enum logic [2:0] {
		UPSF_CMD_CYCLIC = 3'h0,
		UPSF_CMD_DISCOVER = 3'h1,
		UPSF_CMD_ASSIGN = 3'h2,
		UPSF_CMD_MONITOR = 3'h3,
		UPSF_CMD_PARAM_READ = 3'h4,
		UPSF_CMD_OPERATE = 3'h5
	} upsf_cmd_t;
	typedef logic [15:0] upsf_word_t;
endpackage

// [tb/udp_port_station_filter_bench.sv]
// Purpose: Drives the master end and station end across one link
// Assumes: Inputs change at the falling edge, 100 ns clock
// Notes: Event pulses are collected into one word; service checks compare it whole, cyclic checks only its done and timeout bits
`timescale 1ns/1ps
module udp_port_station_filter_bench;
	import upsf_pkg::*;
	localparam logic [10:0] E_ASG = 11'h2;
	localparam logic [10:0] E_REJ = 11'h4;
	localparam logic [10:0] E_DRP = 11'h80;
	logic sys_clk_in, rst_n_in, start, wr, fixed, safe, m_busy, m_rfd, m_rxv, m_done, m_tmo;
	logic s_alarm, s_rxv, e_disc, e_asg, e_rej, e_mon, e_prd, e_opr, e_rfs, e_drp;
	logic [31:0] own_ip, nip, flo, fhi, olo, ohi, s_ip, s_mask, exp_ip;
	logic [15:0] port;
	logic [4:0] addr, s_rxi;
	logic [5:0] stn, hdr_stn;
	logic [10:0] ev;
	upsf_cmd_t cmd;
	upsf_word_t mdat, sdat, m_rxw, s_rxw;
	upsf_word_t mrx [32];
	upsf_word_t srx [32];
	int mcnt, scnt, num_errors, total_checks;
	logic [31:0] ips [4] = '{32'h0, 32'h1, 32'hdffffffe, 32'hdfffffff};
	upsf_link_if link ();
	upsf_master upsf_master_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link),
		.own_ip_in(own_ip), .own_mask_in(32'hffffff00), .target_ip_in(32'hc0a80300),
		.start_in(start), .port_in(port), .cmd_in(cmd), .station_in(stn), .new_ip_in(nip),
		.tx_wr_in(wr), .tx_addr_in(addr), .tx_data_in(mdat), .busy_out(m_busy),
		.refused_out(m_rfd), .rx_valid_out(m_rxv), .rx_word_out(m_rxw), .done_out(m_done),
		.timeout_out(m_tmo));
	upsf_station upsf_station_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link),
		.fixed_proto_in(fixed), .filter_lo_in(flo), .filter_hi_in(fhi), .oper_lo_in(olo),
		.oper_hi_in(ohi), .safety_unit_in(safe), .tx_wr_in(wr), .tx_addr_in(addr),
		.tx_data_in(sdat), .station_ip_out(s_ip), .subnet_mask_out(s_mask),
		.safety_unit_conflict_alarm_out(s_alarm), .rx_valid_out(s_rxv), .rx_index_out(s_rxi),
		.rx_word_out(s_rxw), .node_discovery_request_out(e_disc),
		.address_assign_request_out(e_asg), .assign_reject_out(e_rej), .monitor_out(e_mon),
		.param_read_out(e_prd), .operate_out(e_opr), .refuse_out(e_rfs), .drop_out(e_drp));
	upsf_link_props upsf_link_props_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.hdr_valid(link.hdr_valid), .dst_port(link.dst_port), .cmd(link.cmd),
		.byte_valid(link.byte_valid), .byte_last(link.byte_last), .rsp_valid(link.rsp_valid),
		.rsp_last(link.rsp_last));
	// Pulses stick in ev until the next request clears it
	always @(posedge sys_clk_in) begin
		ev = ev | {m_tmo, m_done, m_rfd, e_drp, e_rfs, e_opr, e_prd, e_mon, e_rej, e_asg, e_disc};
		// Station number carried by the last header on the link
		if (link.hdr_valid) begin
			hdr_stn = link.station;
		end
		if (m_rxv) begin
			mrx[mcnt] = m_rxw;
			mcnt++;
		end
		if (s_rxv) begin
			srx[s_rxi] = s_rxw;
			scnt++;
		end
	end
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		total_checks++;
		if (seen !== expv) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// One service datagram; station answers with an event two edges later
	task automatic svc(input logic [15:0] p, input upsf_cmd_t c, input logic [31:0] ip,
		input logic [10:0] expv);
		@(negedge sys_clk_in);
		ev = 11'h0;
		port = p;
		cmd = c;
		nip = ip;
		start = 1'b1;
		@(negedge sys_clk_in);
		start = 1'b0;
		repeat (4) @(negedge sys_clk_in);
		// Exactly the expected pulses; a rejected assign must not also flag the request
		check(ev, expv);
	endtask
	// Cyclic exchange, bounded wait for completion or master timeout
	task automatic cyc(input logic [10:0] expv);
		int i;
		@(negedge sys_clk_in);
		ev = 11'h0;
		mcnt = 0;
		scnt = 0;
		hdr_stn = 6'h00;
		cmd = UPSF_CMD_CYCLIC;
		start = 1'b1;
		@(negedge sys_clk_in);
		start = 1'b0;
		check(m_busy, 1'b1);
		for (i = 0; i < 2000 && !(ev[9] || ev[10]); i++) @(negedge sys_clk_in);
		// A hung exchange counts once; the rest still runs to the closing report
		if (i == 2000) begin
			check(32'h0, 32'h1);
			return;
		end
		check(ev & 11'h600, expv);
		check(m_busy, 1'b0);
		check(hdr_stn, stn);
		check(mcnt, expv[9] ? 32 : 0);
		check(scnt, expv[9] ? 32 : 0);
		for (i = 0; i < 32 && expv[9]; i++) begin
			check(mrx[i], 32'ha500 | i);
			check(srx[i], 32'h5a00 | i);
		end
		repeat (2) @(negedge sys_clk_in);
	endtask
	initial begin
		{rst_n_in, start, wr, safe, addr, mdat, sdat, nip} = '0;
		{port, ev, mcnt, scnt, num_errors, total_checks} = '0;
		cmd = UPSF_CMD_CYCLIC;
		fixed = 1'b1;
		stn = 6'h3f;
		own_ip = 32'hc0a8030a;
		{flo, olo} = '0;
		{fhi, ohi} = '1;
		repeat (6) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		check(s_ip, 32'hc0a80300);
		check(s_mask, 32'hffffff00);
		for (int k = 0; k < 32; k++) begin
			wr = 1'b1;
			addr = 5'(k);
			mdat = 16'h5a00 | 16'(k);
			sdat = 16'ha500 | 16'(k);
			@(negedge sys_clk_in);
		end
		wr = 1'b0;
		cyc(11'h200);
		cyc(11'h200);
		svc(16'hf00b, UPSF_CMD_DISCOVER, 32'h0, 11'h1);
		svc(16'hb0b5, UPSF_CMD_DISCOVER, 32'h0, E_DRP);
		svc(16'h1392, UPSF_CMD_MONITOR, 32'h0, E_DRP);
		svc(16'h1234, UPSF_CMD_DISCOVER, 32'h0, E_DRP);
		exp_ip = 32'hc0a80300;
		for (int k = 0; k < 4; k++) begin
			exp_ip = (k == 1 || k == 2) ? ips[k] : exp_ip;
			svc(16'hf00b, UPSF_CMD_ASSIGN, ips[k], (k == 1 || k == 2) ? E_ASG : E_REJ);
			check(s_ip, exp_ip);
		end
		safe = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		check(s_alarm, 1'b1);
		svc(16'hf00b, UPSF_CMD_DISCOVER, 32'h0, E_DRP);
		cyc(11'h400);
		fixed = 1'b0;
		@(negedge sys_clk_in);
		check(s_alarm, 1'b0);
		svc(16'hb0b5, UPSF_CMD_DISCOVER, 32'h0, 11'h1);
		svc(16'hf00b, UPSF_CMD_DISCOVER, 32'h0, E_DRP);
		svc(16'hb0b5, UPSF_CMD_ASSIGN, 32'h0, E_ASG);
		check(s_ip, 32'h0);
		svc(16'hb0b5, UPSF_CMD_ASSIGN, 32'hffffffff, E_ASG);
		check(s_ip, 32'hffffffff);
		for (int k = 0; k < 6; k++) begin
			olo = (k < 3) ? 32'h0 : 32'hc0a8030b;
			svc(16'h1392, upsf_cmd_t'(3 + k % 3), 32'h0,
				(k == 5) ? 11'h40 : 11'h8 << (k % 3));
		end
		flo = 32'hc0a8030b;
		svc(16'h1392, UPSF_CMD_MONITOR, 32'h0, E_DRP);
		flo = 32'h0;
		own_ip = 32'hc0a8040a;
		svc(16'h1392, UPSF_CMD_MONITOR, 32'h0, 11'h100);
		summarize();
	end
endmodule // udp_port_station_filter_bench

// [tb/upsf_link_props.sv]
// Purpose: Link checks between the master end and the station end
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees only link wires; station events are judged by the bench
`timescale 1ns/1ps
module upsf_link_props
	import upsf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Link wires
	input wire logic hdr_valid,
	input wire logic [15:0] dst_port,
	input wire upsf_cmd_t cmd,
	input wire logic byte_valid,
	input wire logic byte_last,
	input wire logic rsp_valid,
	input wire logic rsp_last
);
	logic [6:0] beats;
	logic [6:0] next_beats;
	wire cyc_hdr = hdr_valid && (cmd == UPSF_CMD_CYCLIC);
	wire end_in = byte_valid && byte_last;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Answer beat count; a gap restarts it, so a broken answer shows short
	always_comb begin
		next_beats = rsp_valid ? beats + 7'h1 : 7'h0;
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			beats <= 7'h0;
		end else begin
			beats <= next_beats;
		end
	end
	a_hdr_one_beat: assert property (hdr_valid |=> !hdr_valid)
		else $error("header held longer than one cycle");
	a_cyclic_port: assert property (cyc_hdr |-> dst_port == 16'hf00a)
		else $error("cyclic header on wrong port");
	a_payload_start: assert property (cyc_hdr |=> (byte_valid && !byte_last) [*8])
		else $error("cyclic payload not started at once");
	a_payload_len: assert property (cyc_hdr |-> ##64 (byte_valid && byte_last))
		else $error("cyclic payload not 64 bytes");
	a_answer_cause: assert property ($rose(rsp_valid) |-> $past(end_in))
		else $error("answer without a finished request");
	a_answer_count: assert property (rsp_last |-> beats == 7'h3f)
		else $error("answer not 64 contiguous bytes");
	a_answer_whole: assert property ($rose(rsp_valid) |-> !rsp_last ##63 rsp_last)
		else $error("answer last byte misplaced");
	a_answer_close: assert property (rsp_last |=> !rsp_valid)
		else $error("answer runs past last byte");
	a_no_hdr_mid_answer: assert property (rsp_valid |-> !hdr_valid)
		else $error("header during answer");
	c_cyclic: cover property (cyc_hdr);
	c_answer: cover property (rsp_last);
	c_assign: cover property (hdr_valid && cmd == UPSF_CMD_ASSIGN);
endmodule // upsf_link_props
